// file: rtl/pbh_scheme.sv
`timescale 1ns/100ps
module pbh_scheme #(
    parameter int COORD_TICKS   = pbh_pkg::COORD_MS * pbh_pkg::CLK_KHZ,
    parameter int PERSIST_TICKS = pbh_pkg::GND_PERSIST_MS * pbh_pkg::CLK_KHZ,
    parameter int GEXT_TICKS    = pbh_pkg::GND_EXTEND_MS * pbh_pkg::CLK_KHZ,
    parameter int DDROP_TICKS   = pbh_pkg::DIST_DROP_MS * pbh_pkg::CLK_KHZ,
    parameter int DDROP3_TICKS  = pbh_pkg::DIST_DROP_3T_MS * pbh_pkg::CLK_KHZ,
    parameter int ECHO_TICKS    = pbh_pkg::ECHO_WIN_MS * pbh_pkg::CLK_KHZ,
    parameter int ECHO3_TICKS   = pbh_pkg::ECHO_WIN_3T_MS * pbh_pkg::CLK_KHZ,
    parameter int WEAK_TICKS    = pbh_pkg::WEAK_TRIP_MS * pbh_pkg::CLK_KHZ
) (
    // clock and reset
    input  wire logic                    MCLK,
    input  wire logic                    RST_N,
    // settings
    input  wire pbh_pkg::pbh_scheme_type SCHEME_SELECT,
    input  wire pbh_pkg::pbh_cstart_type CARRIER_START_SELECT,
    input  wire logic [1:0]              RECEIVER_COUNT_SETTING,
    input  wire logic                    START_RESTRAINT_FACTOR,
    // measurements and contact inputs
    input  wire pbh_pkg::pbh_meas_type   MEAS,
    input  wire logic                    RECEIVER_ONE_INPUT,
    input  wire logic                    RECEIVER_TWO_INPUT,
    input  wire logic                    EXTERNAL_STOP_CARRIER_INPUT,
    input  wire logic                    PILOT_TRIP_BLOCK_INPUT,
    // outputs
    output logic                         ZONE4_REVERSE,
    output logic                         START_RESTRAINT_EN,
    output logic                         CARRIER_START,
    output logic                         CARRIER_STOP,
    output logic                         PILOT_TRIP
);

    localparam int TW = 32;

    // two-flop synchronisers for every asynchronous input
    logic [12:0] sync1_reg, sync2_reg;
    logic [12:0] async_in;
    assign async_in = {MEAS, RECEIVER_ONE_INPUT, RECEIVER_TWO_INPUT,
                       EXTERNAL_STOP_CARRIER_INPUT, PILOT_TRIP_BLOCK_INPUT, 1'b0};
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_reg <= 13'h0;
            sync2_reg <= 13'h0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    pbh_pkg::pbh_meas_type m;
    logic rx1, rx2, ext_stop, pilot_blk;
    assign m         = pbh_pkg::pbh_meas_type'(sync2_reg[12:5]);
    assign rx1       = sync2_reg[4];
    assign rx2       = sync2_reg[3];
    assign ext_stop  = sync2_reg[2];
    assign pilot_blk = sync2_reg[1];

    logic is_block, is_hybrid, three_term;
    assign is_block   = (SCHEME_SELECT == pbh_pkg::SCM_BLOCKING);
    assign is_hybrid  = (SCHEME_SELECT == pbh_pkg::SCM_HYBRID);
    assign three_term = is_hybrid && (RECEIVER_COUNT_SETTING == 2'(pbh_pkg::RCVR_COUNT_THREE_TERM));

    // zone four reversed in every scheme here, which always needs reverse blocking
    assign ZONE4_REVERSE      = is_block || is_hybrid || (SCHEME_SELECT == pbh_pkg::SCM_POTT2);
    assign START_RESTRAINT_EN = START_RESTRAINT_FACTOR;

    // trip functions override the blocking path
    logic blk_inhibit;
    assign blk_inhibit = m.ovr_trip;

    // timer state
    logic [TW-1:0] persist_reg, persist_next, gext_reg, gext_next, ddrop_reg, ddrop_next;
    logic [TW-1:0] coord_reg, coord_next, echo_reg, echo_next, weak_reg, weak_next;
    logic          gnd_armed_reg, gnd_armed_next, rx_prev_reg, rx_prev_next;
    logic          gnd_blk_out, dist_blk_out, local_block, rx_any, echo_gate, weak_gate, comparer;
    logic [TW-1:0] ddrop_len, echo_len;

    assign ddrop_len = three_term ? TW'(DDROP3_TICKS) : TW'(DDROP_TICKS);
    assign echo_len  = three_term ? TW'(ECHO3_TICKS) : TW'(ECHO_TICKS);

    // blocking outputs: live function or extended dropout, cut by trip functions
    assign gnd_blk_out  = !blk_inhibit && (m.gnd_block || gext_reg != '0);
    assign dist_blk_out = !blk_inhibit && (m.dist_block || ddrop_reg != '0);
    assign local_block  = gnd_blk_out || dist_blk_out;
    assign rx_any       = rx1 || rx2;

    // comparer: overreach, no received block (blocking only), no local block, no oos
    always_comb begin
        if (is_block) begin
            comparer = m.ovr_trip && !rx_any && !local_block && !m.oos_block;
        end else begin
            comparer = m.ovr_trip && rx_any && !local_block && !m.oos_block;
        end
    end

    assign echo_gate = is_hybrid && rx_any && !local_block && (echo_reg != '0);
    assign weak_gate = is_hybrid && !local_block && (m.disturbance || !m.pos_seq_volt)
                       && rx_any && (echo_reg != '0);

    // timer next values
    always_comb begin
        persist_next   = (m.gnd_block && !blk_inhibit && persist_reg != TW'(PERSIST_TICKS))
                         ? persist_reg + TW'(1) : (m.gnd_block && !blk_inhibit ? persist_reg : '0);
        gnd_armed_next = (persist_reg == TW'(PERSIST_TICKS)) || (gnd_armed_reg && m.gnd_block);
        if (blk_inhibit) begin
            gext_next      = '0;
            gnd_armed_next = 1'b0;
        end else if (m.gnd_block && gnd_armed_next) begin
            gext_next = TW'(GEXT_TICKS);
        end else if (gext_reg != '0) begin
            gext_next = gext_reg - TW'(1);
        end else begin
            gext_next = '0;
        end
        if (blk_inhibit) begin
            ddrop_next = '0;
        end else if (m.dist_block) begin
            ddrop_next = ddrop_len;
        end else if (ddrop_reg != '0) begin
            ddrop_next = ddrop_reg - TW'(1);
        end else begin
            ddrop_next = '0;
        end
        coord_next = !comparer ? '0 : (coord_reg == TW'(COORD_TICKS) ? coord_reg : coord_reg + TW'(1));
        rx_prev_next = rx_any;
        if (rx_any && !rx_prev_reg) begin
            echo_next = echo_len; // window opens at receipt
        end else if (!rx_any) begin
            echo_next = '0;
        end else if (echo_reg != '0) begin
            echo_next = echo_reg - TW'(1);
        end else begin
            echo_next = '0;
        end
        weak_next = !weak_gate ? '0 : (weak_reg == TW'(WEAK_TICKS) ? weak_reg : weak_reg + TW'(1));
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            persist_reg   <= '0;
            gext_reg      <= '0;
            ddrop_reg     <= '0;
            coord_reg     <= '0;
            echo_reg      <= '0;
            weak_reg      <= '0;
            gnd_armed_reg <= 1'b0;
            rx_prev_reg   <= 1'b0;
        end else begin
            persist_reg   <= persist_next;
            gext_reg      <= gext_next;
            ddrop_reg     <= ddrop_next;
            coord_reg     <= coord_next;
            echo_reg      <= echo_next;
            weak_reg      <= weak_next;
            gnd_armed_reg <= gnd_armed_next;
            rx_prev_reg   <= rx_prev_next;
        end
    end

    // ground carrier start selection
    logic gnd_start;
    always_comb begin
        case (CARRIER_START_SELECT)
            pbh_pkg::CS_DIR:         gnd_start = m.zero_seq_start && m.reverse_dir;
            pbh_pkg::CS_OVERCURRENT: gnd_start = m.zero_seq_start;
            pbh_pkg::CS_DISTURBANCE: gnd_start = m.disturbance;
            default:                 gnd_start = 1'b0;
        endcase
    end

    // keying and trip outputs, registered
    logic start_next, stop_next, trip_next, start_reg, stop_reg, trip_reg;
    always_comb begin
        if (is_block) begin
            start_next = (gnd_start || local_block) && !m.ovr_trip && !ext_stop;
            stop_next  = m.ovr_trip || ext_stop;
        end else begin
            // permissive keying of the trip frequency, or echo in hybrid
            start_next = (m.ovr_trip && !local_block || echo_gate) && !ext_stop;
            stop_next  = ext_stop;
        end
        trip_next = m.disturbance && !pilot_blk &&
                    ((coord_reg == TW'(COORD_TICKS) && comparer) ||
                     (weak_gate && weak_reg == TW'(WEAK_TICKS)));
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            start_reg <= 1'b0;
            stop_reg  <= 1'b0;
            trip_reg  <= 1'b0;
        end else begin
            start_reg <= start_next;
            stop_reg  <= stop_next;
            trip_reg  <= trip_next;
        end
    end

    assign CARRIER_START = start_reg;
    assign CARRIER_STOP  = stop_reg;
    assign PILOT_TRIP    = trip_reg;

    // assertions
    a_trip_needs_fd: assert property (@(posedge MCLK) disable iff (!RST_N)
        PILOT_TRIP |-> $past(m.disturbance)) else $error("trip without disturbance");
    a_trip_pilot_blk: assert property (@(posedge MCLK) disable iff (!RST_N)
        PILOT_TRIP |-> !$past(pilot_blk)) else $error("trip while pilot blocked");
    a_stop_ext: assert property (@(posedge MCLK) disable iff (!RST_N)
        ext_stop |=> (CARRIER_STOP && !CARRIER_START)) else $error("stop carrier ignored");
    a_block_rx_trip: assert property (@(posedge MCLK) disable iff (!RST_N)
        (is_block && rx_any && !weak_gate) |=> !PILOT_TRIP) else $error("trip despite received block");
    a_ovr_stops_car: assert property (@(posedge MCLK) disable iff (!RST_N)
        (is_block && m.ovr_trip) |=> (CARRIER_STOP && !CARRIER_START)) else $error("carrier not stopped");
    a_coord_delay: assert property (@(posedge MCLK) disable iff (!RST_N)
        (comparer && coord_reg != TW'(COORD_TICKS) && !weak_gate) |=> !PILOT_TRIP) else $error("early trip");
    a_local_blk_trip: assert property (@(posedge MCLK) disable iff (!RST_N)
        (local_block && !weak_gate) |=> !PILOT_TRIP) else $error("trip with local block");
    a_inhibit_blk: assert property (@(posedge MCLK) disable iff (!RST_N)
        m.ovr_trip |-> !local_block) else $error("blocking not inhibited");
    a_dir_start: assert property (@(posedge MCLK) disable iff (!RST_N)
        (is_block && CARRIER_START_SELECT == pbh_pkg::CS_DIR && !m.ovr_trip && !ext_stop
         && !local_block && m.zero_seq_start && !m.reverse_dir) |=> !CARRIER_START)
        else $error("dir start without reverse unit");

    // trip priority: an overreach trip wipes both dropout extensions at once
    a_trip_clears_ext: assert property (@(posedge MCLK) disable iff (!RST_N)
        m.ovr_trip |=> (gext_reg == '0 && ddrop_reg == '0))
        else $error("extension survived trip");

    // weak infeed must wait out its pickup; a spurious receive is held off
    a_weak_wait: assert property (@(posedge MCLK) disable iff (!RST_N)
        (weak_gate && weak_reg != TW'(WEAK_TICKS) && !comparer) |=> !PILOT_TRIP)
        else $error("weak trip before pickup");

    // once the window has run out, only a local overreach may key in hybrid
    a_echo_expired: assert property (@(posedge MCLK) disable iff (!RST_N)
        (is_hybrid && !m.ovr_trip && echo_reg == '0) |=> !CARRIER_START)
        else $error("echo after window");

    // three-terminal hybrid opens the shorter window on a new receipt
    a_three_term_win: assert property (@(posedge MCLK) disable iff (!RST_N)
        (three_term && rx_any && !rx_prev_reg) |=> (echo_reg == TW'(ECHO3_TICKS)))
        else $error("three terminal window wrong");

    // blocking scheme always reverses zone four, no setting involved
    a_zone4_block: assert property (@(posedge MCLK) disable iff (!RST_N)
        is_block |-> ZONE4_REVERSE)
        else $error("zone four not reversed");

    // permissive schemes never trip on the comparer without a receipt
    a_perm_needs_rx: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!is_block && !rx_any && !weak_gate) |=> !PILOT_TRIP)
        else $error("permissive trip without receipt");

    // live distance block reloads the dropout with the length for this setting
    a_dist_extend: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!blk_inhibit && m.dist_block) |=> (ddrop_reg == $past(ddrop_len)))
        else $error("distance dropout not loaded");

    // armed ground block keeps its extension topped up while it stands
    a_ground_arm: assert property (@(posedge MCLK) disable iff (!RST_N)
        (gnd_armed_reg && m.gnd_block && !blk_inhibit) |=> (gext_reg == TW'(GEXT_TICKS)))
        else $error("ground extension not loaded");

    // disturbance start keys the carrier when nothing stops it
    a_fd_start: assert property (@(posedge MCLK) disable iff (!RST_N)
        (is_block && CARRIER_START_SELECT == pbh_pkg::CS_DISTURBANCE && m.disturbance
         && !m.ovr_trip && !ext_stop) |=> CARRIER_START)
        else $error("disturbance start missing");

    // echo keying check and coverage of the main scenarios
    a_echo_key: assert property (@(posedge MCLK) disable iff (!RST_N)
        (echo_gate && !ext_stop) |=> CARRIER_START) else $error("echo not keyed");
    c_block_trip: cover property (@(posedge MCLK) disable iff (!RST_N) is_block && PILOT_TRIP);
    c_echo: cover property (@(posedge MCLK) disable iff (!RST_N) echo_gate);
    c_weak_trip: cover property (@(posedge MCLK) disable iff (!RST_N) weak_gate && PILOT_TRIP);
    c_gnd_extend: cover property (@(posedge MCLK) disable iff (!RST_N) gnd_armed_reg && !m.gnd_block);

endmodule

// file: inc/pbh_pkg.sv
package pbh_pkg;

    // scheme selection and carrier start selection encodings
    typedef enum logic [1:0] {SCM_POTT2, SCM_BLOCKING, SCM_HYBRID} pbh_scheme_type;
    typedef enum logic [1:0] {CS_DIR, CS_OVERCURRENT, CS_DISTURBANCE} pbh_cstart_type;

    // clock rate and timer figures in milliseconds
    localparam int CLK_KHZ              = 125000;
    localparam int COORD_MS             = 2;
    localparam int GND_PERSIST_MS       = 25;
    localparam int GND_EXTEND_MS        = 30;
    localparam int DIST_DROP_MS         = 30;
    localparam int DIST_DROP_3T_MS      = 60;
    localparam int ECHO_WIN_MS          = 80;
    localparam int ECHO_WIN_3T_MS       = 50;
    localparam int WEAK_TRIP_MS         = 4;
    localparam int RCVR_COUNT_THREE_TERM = 2;

    // measurement inputs carried together
    typedef struct packed {
        logic ovr_trip;       // overreaching trip functions, phase and ground
        logic gnd_block;      // ground directional overcurrent blocking function
        logic dist_block;     // zone-four phase and ground distance blocking
        logic zero_seq_start; // zero-sequence start detector, restraint applied upstream
        logic reverse_dir;    // reverse direction unit
        logic disturbance;    // disturbance detector
        logic pos_seq_volt;   // positive-sequence voltage detector picked up
        logic oos_block;      // out-of-step block
    } pbh_meas_type;

endpackage

// file: tb/pbh_channel_model.sv
`timescale 1ns/100ps
// on-off channel: far-end key reaches our receiver after a lag
module pbh_channel_model #(
    parameter int LAG = 2
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // local keying, far-end key
    input  wire logic carrier_start,
    input  wire logic carrier_stop,
    input  wire logic remote_key,
    // receiver contact, local tx state
    output logic      rx_out,
    output logic      tx_on
);
    logic [7:0] pipe_reg;
    // a longer lag models a slow channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pipe_reg <= 8'h00;
            tx_on    <= 1'b0;
        end else begin
            pipe_reg <= {pipe_reg[6:0], remote_key};
            tx_on    <= carrier_start & ~carrier_stop; // stop wins
        end
    end
    assign rx_out = pipe_reg[LAG-1];
endmodule

// file: tb/pbh_scheme_tb_top.sv
`timescale 1ns/100ps
module pbh_scheme_tb_top;
    localparam int L = 2;
    localparam int COORD = 4;
    logic mclk, rst_n, rf, rx2, esc, ptb, rkey, zs, rd, ds;
    logic z4, sre, cst, csp, trip, rx1, txon;
    logic [1:0] rcnt;
    pbh_pkg::pbh_scheme_type scm;
    pbh_pkg::pbh_cstart_type css;
    pbh_pkg::pbh_meas_type   meas;
    int err_total, n_tests, s, r, win, t0;
    int t = 0;

    pbh_scheme #(.COORD_TICKS(COORD), .PERSIST_TICKS(10), .GEXT_TICKS(12), .DDROP_TICKS(12),
        .DDROP3_TICKS(24), .ECHO_TICKS(32), .ECHO3_TICKS(20), .WEAK_TICKS(6)) i_pbh_scheme (
        .MCLK(mclk), .RST_N(rst_n), .SCHEME_SELECT(scm), .CARRIER_START_SELECT(css),
        .RECEIVER_COUNT_SETTING(rcnt), .START_RESTRAINT_FACTOR(rf), .MEAS(meas),
        .RECEIVER_ONE_INPUT(rx1), .RECEIVER_TWO_INPUT(rx2), .EXTERNAL_STOP_CARRIER_INPUT(esc),
        .PILOT_TRIP_BLOCK_INPUT(ptb), .ZONE4_REVERSE(z4), .START_RESTRAINT_EN(sre),
        .CARRIER_START(cst), .CARRIER_STOP(csp), .PILOT_TRIP(trip));
    pbh_channel_model #(.LAG(L)) i_pbh_channel_model (.clk(mclk), .rst_n(rst_n),
        .carrier_start(cst), .carrier_stop(csp), .remote_key(rkey), .rx_out(rx1), .tx_on(txon));

    // free-running clock and cycle count
    always #4 mclk = ~mclk;
    always @(posedge mclk) t <= t + 1;

    function automatic logic exp_start(input int sel, input logic a, input logic b, input logic c);
        case (sel)
            0: return a & b;
            1: return a;
            2: return c;
            default: return 1'b0;
        endcase
    endfunction

    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task chk(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // bounded wait; a hang ends the run at once
    task wait_trip(input int b);
        for (int i = 0; i < b && trip !== 1'b1; i++) begin
            cyc(1);
        end
        chk("trip", 1'b1, trip);
        if (trip !== 1'b1) begin
            end_sim();
        end
    endtask

    // idle long enough for every extension and window to drain
    task clear_in;
        @(posedge mclk);
        meas <= '0;
        rkey <= 1'b0;
        rx2  <= 1'b0;
        esc  <= 1'b0;
        ptb  <= 1'b0;
        cyc(40);
    endtask

    initial begin
        void'($urandom(32'hd3e9));
        {mclk, rst_n, rf, rx2, esc, ptb, rkey, err_total, n_tests} = '0;
        scm = pbh_pkg::SCM_BLOCKING;
        css = pbh_pkg::CS_DIR;
        rcnt = 2'h1;
        meas = '0;
        cyc(1);
        chk("trip in reset", 1'b0, trip | cst | csp);
        @(posedge mclk);
        rst_n <= 1'b1;
        // settings pass straight through
        for (s = 0; s < 4; s++) begin
            @(posedge mclk);
            scm <= pbh_pkg::pbh_scheme_type'(2'(s));
            rf  <= 1'($urandom);
            cyc(1);
            chk("zone4_reverse", s != 3, z4);
            chk("restraint_en", rf, sre);
        end
        $display("test settings done");
        // overreach trip with each way of being held off
        scm <= pbh_pkg::SCM_BLOCKING;
        for (s = 0; s < 6; s++) begin
            @(posedge mclk);
            meas <= '{ovr_trip: 1'b1, disturbance: (s != 4), oos_block: (s == 5),
                      pos_seq_volt: 1'($urandom), default: 1'b0};
            rkey <= (s == 1);
            rx2  <= (s == 2);
            ptb  <= (s == 3);
            cyc(4);
            chk("carrier_stop", 1'b1, csp);
            chk("carrier_start", 1'b0, cst);
            chk("tx_on", 1'b0, txon);
            chk("early trip", 1'b0, trip);
            if (s == 0) begin
                wait_trip(COORD + 4);
            end else begin
                cyc(COORD + 6);
                chk("held trip", 1'b0, trip);
            end
            clear_in();
        end
        $display("test blocking trip done");
        // ground carrier start selection and external stop
        for (s = 0; s < 4; s++) begin
            for (r = 0; r < 3; r++) begin
                @(posedge mclk);
                zs = (r == 1) | 1'($urandom);
                rd = (r == 1) | 1'($urandom);
                ds = (r == 1) | 1'($urandom);
                css  <= pbh_pkg::pbh_cstart_type'(2'(s));
                meas <= '{zero_seq_start: zs, reverse_dir: rd, disturbance: ds, default: 1'b0};
                esc  <= (r == 2);
                cyc(4);
                chk("carrier_start", exp_start(s, zs, rd, ds) & (r != 2), cst);
                clear_in();
            end
        end
        $display("test carrier start done");
        // persisting ground block keeps carrier after it clears
        @(posedge mclk);
        meas <= '{gnd_block: 1'b1, default: 1'b0};
        cyc(16);
        chk("carrier_start", 1'b1, cst);
        @(posedge mclk);
        meas <= '0;
        cyc(10);
        chk("extended start", 1'b1, cst);
        chk("tx_on extended", 1'b1, txon);
        cyc(10);
        chk("extension end", 1'b0, cst);
        clear_in();
        $display("test ground extension done");
        // distance block keys carrier, extends dropout, yields to overreach
        @(posedge mclk);
        meas <= '{dist_block: 1'b1, default: 1'b0};
        cyc(6);
        chk("dist start", 1'b1, cst);
        @(posedge mclk);
        meas <= '0;
        cyc(8);
        chk("dist extended", 1'b1, cst);
        cyc(10);
        chk("dist extension end", 1'b0, cst);
        @(posedge mclk);
        meas <= '{dist_block: 1'b1, ovr_trip: 1'b1, disturbance: 1'b1, default: 1'b0};
        cyc(4);
        chk("dist overridden", 1'b0, cst);
        wait_trip(COORD + 8);
        clear_in();
        $display("test distance block done");
        // hybrid echo and weak infeed, two and three terminals
        scm <= pbh_pkg::SCM_HYBRID;
        for (s = 1; s < 3; s++) begin
            @(posedge mclk);
            rcnt <= 2'(s);
            meas <= '{disturbance: 1'b1, default: 1'b0};
            rkey <= 1'b1;
            t0 = t;
            win = (s == 2) ? 20 : 32;
            cyc(L + 4);
            chk("echo", 1'b1, cst);
            chk("early weak trip", 1'b0, trip);
            wait_trip(12);
            while (t < t0 + L + win - 2) cyc(1);
            chk("echo late", 1'b1, cst);
            while (t < t0 + L + win + 8) cyc(1);
            chk("echo over", 1'b0, cst);
            chk("weak trip over", 1'b0, trip);
            clear_in();
        end
        $display("test hybrid done");
        // reset in mid-trip drops the trip and both carrier outputs
        @(posedge mclk);
        scm  <= pbh_pkg::SCM_BLOCKING;
        meas <= '{ovr_trip: 1'b1, disturbance: 1'b1, default: 1'b0};
        wait_trip(COORD + 10);
        @(posedge mclk);
        rst_n <= 1'b0;
        cyc(1);
        chk("reset outputs", 1'b0, trip | csp | cst);
        $display("test reset done");
        end_sim();
    end
endmodule
